// ### rtl/vbic_pkg.sv
// Purpose: constants and types for the video buffer i2c configuration block
// Assumes: i2c target, 7-bit addressing, sys_clk far faster than scl
// Notes:   channel and control register layouts
package vbic_pkg;
  localparam logic [4:0] ADDR_FIXED      = 5'h0B;
  localparam logic [7:0] IDX_CH_FIRST    = 8'h01;
  localparam logic [7:0] IDX_CH_LAST     = 8'h03;
  localparam logic [7:0] IDX_CTRL        = 8'h04;
  localparam int         NUM_CH          = 3;
  localparam logic [7:0] CH_RESET_OFF    = 8'h00;
  localparam logic [7:0] CH_RESET_ON     = 8'h04;
  localparam logic [7:0] CTRL_RESET_OFF  = 8'h00;
  localparam logic [7:0] CTRL_RESET_ON   = 8'h40;
  localparam int         CH_FILT_BIT     = 7;
  localparam int         CH_MUX_HI       = 6;
  localparam int         CH_MUX_LO       = 3;
  localparam int         CH_MODE_HI      = 2;
  localparam int         CTRL_MON_BIT    = 6;
  localparam int         CTRL_BUF_BIT    = 5;
  localparam int         CTRL_VS_HI      = 4;
  localparam int         CTRL_VS_LO      = 3;
  localparam int         CTRL_HS_HI      = 2;
  localparam int         CTRL_HS_LO      = 1;
  localparam int         CTRL_SYNC_BIT   = 0;
  localparam logic [3:0] MUX_B_FIRST     = 4'h5;
  localparam logic [2:0] MODE_OFF        = 3'h0;
  localparam logic [2:0] MODE_AC_CLAMP   = 3'h5;
  localparam logic [3:0] BIT_LAST        = 4'h7;
  localparam logic [3:0] BIT_ACK         = 4'h8;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_IDX, ST_DATA, ST_RD, ST_ACK, ST_RACK, ST_SKIP} vbic_state_t;

  typedef struct packed {
    logic [2:0] mode;
    logic       monEn;
    logic       bufEn;
    logic       muxB;
    logic       wideFilt;
  } vbic_chan_t;

  typedef struct packed {
    logic [1:0]  sclSync;
    logic [1:0]  sdaSync;
    logic        sclPrev;
    logic        sdaPrev;
    logic        strapSeen;
    vbic_state_t state;
    vbic_state_t after;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic [7:0]  index;
    logic        sdaOe;
    logic [NUM_CH-1:0][7:0] ch;
    logic [7:0]  ctrl;
  } vbic_regs_t;
endpackage

// ### rtl/vbic_top.sv
// Purpose: i2c target with three channel registers and one control register
// Assumes: scl/sda are open drain pins, oversampled by sys_clk through two flops
// Notes:   no clock stretching; registers decode into path enables
`timescale 1ns/10ps
// What this block does
// R01: bit 7 picks clamp filter in ac-clamp mode
// R02: bits 6..3 pick channel mux input
// R03: bits 2..0 set mode, not gated by master bits
// R04: control bit 7 reserved, no effect
// R05: control bit 6 low disables monitor paths
// R06: control bit 5 low disables buffer paths
// R07: control bits 4..3 pick vertical sync input
// R08: control bits 2..1 pick horizontal sync input
// R09: control bit 0 enables both sync paths
// R10: master writes address, index, then data
// R11: index upper five bits zero, lower three select
// R12: device acknowledges index and data bytes
// R13: one register per transaction only
// R14: read phase one sets index, then stop
// R15: read phase two uses read bit set
// R16: device returns selected register, master nacks
// R17: address is 01011, two strap bits, rw
// R18: index 1..3 channels, index 4 control
// R19: strap pin chooses power-up register contents
// R20: writes to other indices change nothing
module vbic_top (
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  input  wire logic                     sclIn,
  input  wire logic                     sdaIn,
  output logic                          sdaOut,
  output logic                          sdaOe,
  input  wire logic                     addr_select_high_pin,
  input  wire logic                     addr_select_low_pin,
  input  wire logic                     powerup_strap_pin,
  output vbic_pkg::vbic_chan_t [2:0]    chanCfg,
  output logic                          vsyncMuxB,
  output logic                          hsyncMuxB,
  output logic                          syncEn
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]           rstSync;
  logic                 rstn;
  vbic_pkg::vbic_regs_t r_reg;
  vbic_pkg::vbic_regs_t r_next;
  logic [1:0]           strapSync;
  logic [1:0]           addrSync [2];
  logic                 scl;
  logic                 sda;
  logic                 sclRise;
  logic                 sclFall;
  logic                 startSeen;
  logic                 stopSeen;
  logic                 idxOk;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstn = rstSync[1];

  // straps and pins pass two flops; the first stage is read by nothing else
  // no reset here: the strap has settled in the second flop before the internal reset lifts
  always_ff @(posedge sys_clk) begin
    strapSync   <= {strapSync[0], powerup_strap_pin};
    addrSync[0] <= {addr_select_high_pin, addr_select_low_pin};
    addrSync[1] <= addrSync[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  assign scl       = r_reg.sclSync[1];
  assign sda       = r_reg.sdaSync[1];
  assign sclRise   = scl && !r_reg.sclPrev;
  assign sclFall   = !scl && r_reg.sclPrev;
  assign startSeen = scl && r_reg.sclPrev && r_reg.sdaPrev && !sda;
  assign stopSeen  = scl && r_reg.sclPrev && !r_reg.sdaPrev && sda;
  assign idxOk     = (r_reg.index >= vbic_pkg::IDX_CH_FIRST) && (r_reg.index <= vbic_pkg::IDX_CTRL); // R18

  always_comb begin
    r_next         = r_reg;
    r_next.sclSync = {r_reg.sclSync[0], sclIn};
    r_next.sdaSync = {r_reg.sdaSync[0], sdaIn};
    r_next.sclPrev = scl;
    r_next.sdaPrev = sda;
    // strap caught once after reset release; holds until a valid write
    if (!r_reg.strapSeen) begin
      r_next.strapSeen = 1'b1;
      for (int i = 0; i < vbic_pkg::NUM_CH; i++) begin
        r_next.ch[i] = strapSync[1] ? vbic_pkg::CH_RESET_ON : vbic_pkg::CH_RESET_OFF; // R19
      end
      r_next.ctrl = strapSync[1] ? vbic_pkg::CTRL_RESET_ON : vbic_pkg::CTRL_RESET_OFF; // R19
    end
    if (startSeen) begin
      r_next.state  = vbic_pkg::ST_ADDR;
      r_next.bitCnt = 4'h0;
      r_next.sdaOe  = 1'b1;
    end else if (stopSeen) begin
      r_next.state = vbic_pkg::ST_IDLE;
      r_next.sdaOe = 1'b1;
    end else if (sclRise) begin
      unique case (r_reg.state)
        vbic_pkg::ST_ADDR, vbic_pkg::ST_IDX, vbic_pkg::ST_DATA: begin
          r_next.shift  = {r_reg.shift[6:0], sda};
          r_next.bitCnt = r_reg.bitCnt + 4'h1;
        end
        vbic_pkg::ST_RD: begin
          r_next.bitCnt = r_reg.bitCnt + 4'h1;
        end
        vbic_pkg::ST_RACK: begin
          // ack or nack from the master both close the single-byte read
          r_next.state = vbic_pkg::ST_SKIP; // R16
        end
        default: begin
        end
      endcase
    end else if (sclFall) begin
      unique case (r_reg.state)
        vbic_pkg::ST_ADDR: begin
          if (r_reg.bitCnt == vbic_pkg::BIT_ACK) begin
            if (r_reg.shift[7:1] == {vbic_pkg::ADDR_FIXED, addrSync[1]}) begin // R17
              r_next.sdaOe  = 1'b0;
              r_next.state  = vbic_pkg::ST_ACK;
              r_next.after  = r_reg.shift[0] ? vbic_pkg::ST_RD : vbic_pkg::ST_IDX; // R15
            end else begin
              r_next.state = vbic_pkg::ST_SKIP;
            end
            r_next.bitCnt = 4'h0;
          end
        end
        vbic_pkg::ST_IDX: begin
          if (r_reg.bitCnt == vbic_pkg::BIT_ACK) begin
            r_next.index  = r_reg.shift; // R14
            r_next.sdaOe  = 1'b0; // R12
            r_next.state  = vbic_pkg::ST_ACK;
            r_next.after  = vbic_pkg::ST_DATA;
            r_next.bitCnt = 4'h0;
          end
        end
        vbic_pkg::ST_DATA: begin
          if (r_reg.bitCnt == vbic_pkg::BIT_ACK) begin
            // upper five index bits must be zero for any write to land
            if (idxOk) begin // R11 R20
              if (r_reg.index == vbic_pkg::IDX_CTRL) begin
                r_next.ctrl = r_reg.shift;
              end else begin
                r_next.ch[r_reg.index[1:0] - 2'd1] = r_reg.shift;
              end
            end
            r_next.sdaOe  = 1'b0; // R12
            r_next.state  = vbic_pkg::ST_ACK;
            r_next.after  = vbic_pkg::ST_SKIP; // R13
            r_next.bitCnt = 4'h0;
          end
        end
        vbic_pkg::ST_ACK: begin
          r_next.state = r_reg.after;
          r_next.sdaOe = 1'b1;
          if (r_reg.after == vbic_pkg::ST_RD) begin
            // unmapped index reads back zero
            r_next.shift = !idxOk ? 8'h00 :
                           (r_reg.index == vbic_pkg::IDX_CTRL) ? r_reg.ctrl : r_reg.ch[r_reg.index[1:0] - 2'd1]; // R16
            r_next.sdaOe = !((!idxOk ? 1'b0 : (r_reg.index == vbic_pkg::IDX_CTRL) ? r_reg.ctrl[7]
                             : r_reg.ch[r_reg.index[1:0] - 2'd1][7]) == 1'b0);
          end
        end
        vbic_pkg::ST_RD: begin
          if (r_reg.bitCnt == vbic_pkg::BIT_LAST + 4'h1) begin
            r_next.sdaOe = 1'b1;
            r_next.state = vbic_pkg::ST_RACK;
          end else begin
            r_next.shift = {r_reg.shift[6:0], 1'b0};
            r_next.sdaOe = r_reg.shift[6];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r_reg.sclSync   <= 2'b11;
      r_reg.sdaSync   <= 2'b11;
      r_reg.sclPrev   <= 1'b1;
      r_reg.sdaPrev   <= 1'b1;
      r_reg.strapSeen <= 1'b0;
      r_reg.state     <= vbic_pkg::ST_IDLE;
      r_reg.after     <= vbic_pkg::ST_IDLE;
      r_reg.bitCnt    <= 4'h0;
      r_reg.shift     <= 8'h00;
      r_reg.index     <= 8'h00;
      r_reg.sdaOe     <= 1'b1;
      r_reg.ch[0]     <= vbic_pkg::CH_RESET_OFF;
      r_reg.ch[1]     <= vbic_pkg::CH_RESET_OFF;
      r_reg.ch[2]     <= vbic_pkg::CH_RESET_OFF;
      r_reg.ctrl      <= vbic_pkg::CTRL_RESET_OFF;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded outputs registered so every output comes from a flop
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      chanCfg   <= '0;
      vsyncMuxB <= 1'b0;
      hsyncMuxB <= 1'b0;
      syncEn    <= 1'b0;
      sdaOut    <= 1'b0;
      sdaOe     <= 1'b1;
    end else begin
      for (int i = 0; i < vbic_pkg::NUM_CH; i++) begin
        chanCfg[i].mode     <= r_reg.ch[i][vbic_pkg::CH_MODE_HI:0]; // R03
        chanCfg[i].monEn    <= r_reg.ctrl[vbic_pkg::CTRL_MON_BIT] &&
                               (r_reg.ch[i][vbic_pkg::CH_MODE_HI:0] != vbic_pkg::MODE_OFF); // R05
        chanCfg[i].bufEn    <= r_reg.ctrl[vbic_pkg::CTRL_BUF_BIT] &&
                               (r_reg.ch[i][vbic_pkg::CH_MODE_HI:0] != vbic_pkg::MODE_OFF); // R06
        chanCfg[i].muxB     <= r_reg.ch[i][vbic_pkg::CH_MUX_HI:vbic_pkg::CH_MUX_LO] >= vbic_pkg::MUX_B_FIRST; // R02
        chanCfg[i].wideFilt <= r_reg.ch[i][vbic_pkg::CH_FILT_BIT] &&
                               (r_reg.ch[i][vbic_pkg::CH_MODE_HI:0] >= vbic_pkg::MODE_AC_CLAMP); // R01
      end
      // reserved codes fall back to input a; control bit 7 feeds no decoded output, only readback
      vsyncMuxB <= r_reg.ctrl[vbic_pkg::CTRL_VS_HI:vbic_pkg::CTRL_VS_LO] == 2'b01; // R07 R04
      hsyncMuxB <= r_reg.ctrl[vbic_pkg::CTRL_HS_HI:vbic_pkg::CTRL_HS_LO] == 2'b01; // R08
      syncEn    <= r_reg.ctrl[vbic_pkg::CTRL_SYNC_BIT]; // R09
      sdaOut    <= 1'b0;
      sdaOe     <= r_reg.sdaOe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_SYNC_EN: assert property (@(posedge sys_clk) disable iff (!rstn)
    ##1 syncEn == $past(r_reg.ctrl[0])) else $error("sync enable does not follow control bit 0"); // R09
  AST_MON_OFF: assert property (@(posedge sys_clk) disable iff (!rstn)
    !r_reg.ctrl[6] |=> !chanCfg[0].monEn && !chanCfg[1].monEn && !chanCfg[2].monEn)
    else $error("monitor path on while master bit low"); // R05
  AST_BUF_OFF: assert property (@(posedge sys_clk) disable iff (!rstn)
    !r_reg.ctrl[5] |=> !chanCfg[0].bufEn && !chanCfg[1].bufEn && !chanCfg[2].bufEn)
    else $error("buffer path on while master bit low"); // R06
  AST_VS_SEL: assert property (@(posedge sys_clk) disable iff (!rstn)
    r_reg.ctrl[4:3] == 2'b01 |=> vsyncMuxB) else $error("vertical sync not on input b"); // R07
  AST_HS_SEL: assert property (@(posedge sys_clk) disable iff (!rstn)
    r_reg.ctrl[2:1] == 2'b00 |=> !hsyncMuxB) else $error("horizontal sync not on input a"); // R08
  AST_MUX_B: assert property (@(posedge sys_clk) disable iff (!rstn)
    r_reg.ch[0][6:3] == 4'h5 |=> chanCfg[0].muxB) else $error("code 5 must pick input b"); // R02
  AST_FILT: assert property (@(posedge sys_clk) disable iff (!rstn)
    r_reg.ch[1][2:0] < 3'h5 |=> !chanCfg[1].wideFilt) else $error("filter active outside clamp mode"); // R01
  AST_MODE: assert property (@(posedge sys_clk) disable iff (!rstn)
    ##1 chanCfg[2].mode == $past(r_reg.ch[2][2:0])) else $error("channel mode not passed through"); // R03
  AST_BAD_IDX: assert property (@(posedge sys_clk) disable iff (!rstn)
    r_reg.strapSeen && !idxOk |=> r_reg.ctrl == $past(r_reg.ctrl)) else $error("write to bad index changed control"); // R20
endmodule

// ### testbench/tb.sv
// Purpose: self-checking bench for the video buffer i2c configuration block
// Assumes: address pins normally high and low, so the write address byte is 0x5C
// Notes:   scenarios run in order and share register state
`timescale 1ns/10ps
module tb;
  localparam logic [7:0] DEV_W = 8'h5C;
  logic                       sys_clk;
  logic                       resetn;
  logic                       strap;
  logic                       addrHi;
  logic                       addrLo;
  logic                       sclOut;
  logic                       sdaLow;
  logic                       sdaOut;
  logic                       sdaOe;
  logic                       vsyncMuxB;
  logic                       hsyncMuxB;
  logic                       syncEn;
  vbic_pkg::vbic_chan_t [2:0] chanCfg;
  wire logic                  sdaLine;
  int                         err_total;
  int                         compares;
  // pull-up wire; sdaOe low means the block pulls the line
  assign sdaLine = ~sdaLow & (sdaOe ? 1'h1 : sdaOut);
  vbic_top i_vbic_top (.sys_clk(sys_clk), .resetn(resetn), .sclIn(sclOut), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_select_high_pin(addrHi), .addr_select_low_pin(addrLo),
    .powerup_strap_pin(strap), .chanCfg(chanCfg), .vsyncMuxB(vsyncMuxB), .hsyncMuxB(hsyncMuxB),
    .syncEn(syncEn));
  vbic_i2c_master i_vbic_i2c_master (.sys_clk(sys_clk), .sdaLine(sdaLine), .sclOut(sclOut), .sdaLow(sdaLow));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic sb(input logic [7:0] d, input logic expAck);
    logic a;
    i_vbic_i2c_master.send_byte(d, a);
    chk({7'h0, a}, {7'h0, expAck});
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    i_vbic_i2c_master.start_cond();
    sb(DEV_W, 1'h1);
    sb(idx, 1'h1);
    sb(d, 1'h1);
    i_vbic_i2c_master.stop_cond();
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    i_vbic_i2c_master.start_cond();
    sb(DEV_W, 1'h1);
    sb(idx, 1'h1);
    i_vbic_i2c_master.stop_cond();
    i_vbic_i2c_master.start_cond();
    sb(DEV_W | 8'h01, 1'h1);
    i_vbic_i2c_master.recv_byte(d);
    i_vbic_i2c_master.stop_cond();
    chk(d, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_powerup(input logic s);
    @(posedge sys_clk);
    resetn <= 1'h0;
    strap <= s;
    i_vbic_i2c_master.tick(2);
    resetn <= 1'h1;
    i_vbic_i2c_master.tick(12);
    chk({5'h0, vsyncMuxB, hsyncMuxB, syncEn}, 8'h00);
    for (int k = 0; k < 3; k++) begin
      chk({1'h0, chanCfg[k]}, s ? 8'h48 : 8'h00);
      rd(8'(k + 1), s ? 8'h04 : 8'h00);
    end
    rd(8'h04, s ? 8'h40 : 8'h00);
  endtask
  task automatic t_channels();
    logic [7:0] regVal [4] = '{8'hAD, 8'hA2, 8'h4F, 8'h61};
    logic [7:0] cfgExp [3] = '{8'h5F, 8'h2C, 8'h7E};
    for (int k = 0; k < 4; k++) begin
      wr(8'(k + 1), regVal[k]);
    end
    i_vbic_i2c_master.tick(4);
    for (int k = 0; k < 3; k++) begin
      chk({1'h0, chanCfg[k]}, cfgExp[k]);
    end
    for (int k = 0; k < 4; k++) begin
      rd(8'(k + 1), regVal[k]);
    end
  endtask
  // every sync code and both master disables, reserved bit set once
  task automatic t_ctrl();
    logic [7:0] c [4] = '{8'h8A, 8'h71, 8'h5E, 8'h24};
    logic [7:0] e;
    for (int k = 0; k < 4; k++) begin
      wr(8'h04, c[k]);
      i_vbic_i2c_master.tick(4);
      e = {3'h0, c[k][4:3] == 2'h1, c[k][2:1] == 2'h1, c[k][0], c[k][6], c[k][5]};
      chk({3'h0, vsyncMuxB, hsyncMuxB, syncEn, chanCfg[0].monEn, chanCfg[0].bufEn}, e);
    end
  endtask
  task automatic t_refuse();
    i_vbic_i2c_master.start_cond();
    sb(8'h5A, 1'h0);
    i_vbic_i2c_master.stop_cond();
    wr(8'h05, 8'hFF);
    wr(8'h0C, 8'h61);
    i_vbic_i2c_master.start_cond();
    sb(DEV_W, 1'h1);
    sb(8'h02, 1'h1);
    sb(8'h33, 1'h1);
    sb(8'h55, 1'h0);
    i_vbic_i2c_master.stop_cond();
    rd(8'h02, 8'h33);
    rd(8'h03, 8'h4F);
    rd(8'h04, 8'h24);
    rd(8'h01, 8'hAD);
    rd(8'h05, 8'h00);
  endtask
  // move the address pins: the old address must go unanswered, the new one lands
  task automatic t_addr();
    i_vbic_i2c_master.tick(1);
    addrHi <= 1'h0;
    addrLo <= 1'h1;
    i_vbic_i2c_master.tick(4);
    i_vbic_i2c_master.start_cond();
    sb(DEV_W, 1'h0);
    i_vbic_i2c_master.stop_cond();
    i_vbic_i2c_master.start_cond();
    sb(8'h5A, 1'h1);
    sb(8'h03, 1'h1);
    sb(8'h4E, 1'h1);
    i_vbic_i2c_master.stop_cond();
    addrHi <= 1'h1;
    addrLo <= 1'h0;
    i_vbic_i2c_master.tick(4);
    rd(8'h03, 8'h4E);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    resetn = 1'h0;
    strap = 1'h0;
    addrHi = 1'h1;
    addrLo = 1'h0;
    err_total = 0;
    compares = 0;
    t_powerup(1'h0);
    t_powerup(1'h1);
    t_channels();
    t_ctrl();
    t_refuse();
    t_addr();
    summarize();
  end
  // whole run needs about 11k cycles; allow over six times that
  initial begin
    #600000;
    err_total++;
    summarize();
  end
endmodule

// ### testbench/vbic_i2c_master.sv
// Purpose: i2c master model driving the configuration block's link
// Assumes: one bit takes 10 sys_clk cycles (80 ns scl period)
// Notes:   scl stands high between frames; released sda floats to the pull-up
`timescale 1ns/10ps
module vbic_i2c_master (
  input  wire logic sys_clk,
  input  wire logic sdaLine,
  output logic      sclOut,
  output logic      sdaLow
);
  initial begin
    sclOut = 1'h1;
    sdaLow = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic start_cond();
    tick(1);
    sdaLow <= 1'h1;
    tick(5);
    sclOut <= 1'h0;
  endtask
  // every frame is closed by a stop, never left hanging
  task automatic stop_cond();
    tick(1);
    sdaLow <= 1'h1;
    tick(4);
    sclOut <= 1'h1;
    tick(5);
    sdaLow <= 1'h0;
    tick(5);
  endtask
  // sda changes only while scl is low; sampled mid high phase, off the edge
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sdaLow <= ~b;
    tick(4);
    sclOut <= 1'h1;
    tick(2);
    @(negedge sys_clk);
    r = sdaLine;
    tick(3);
    sclOut <= 1'h0;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'h1, r);
    ack = ~r;
  endtask
  // a single byte is taken, then a not-acknowledge
  task automatic recv_byte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, d[i]);
    end
    bit_io(1'h1, r);
  endtask
endmodule
